// File: core/gpio_port_cfg.svh
// Constants for the port and line controller block.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH
`define NUM_PINS 16
`define NUM_LINES 26
`define NUM_CFG_LINES 16
`define NUM_INT_LINES 10
`define NUM_SRC_PINS 38
`define SEL_W 6
`define AF_W 4
`define SHARED_PIN 9
`define SPEED_40MHZ_KHZ 40000
`define SPEED_10MHZ_KHZ 10000
`define SPEED_2MHZ_KHZ 2000
`define SPEED_400KHZ_KHZ 400
`define CLOCK_KHZ 50000
`define IOBUS_MHZ 32
`define KEY_CYC_MAX 8'd50
`endif

// File: core/gpio_port_pkg.sv
// Types shared by the port and line controller block.
package gpio_port_pkg;
    typedef enum logic [1:0] {MODE_INPUT, MODE_OUTPUT, MODE_ALT, MODE_ANALOG} pin_mode_e;
    typedef enum logic [1:0] {PULL_NONE, PULL_UP, PULL_DOWN, PULL_RSVD} pull_e;
    typedef enum logic [1:0] {SPD_400K, SPD_2M, SPD_10M, SPD_40M} speed_e;
    typedef enum logic [1:0] {TRIG_NONE, TRIG_RISE, TRIG_FALL, TRIG_BOTH} trig_e;
endpackage : gpio_port_pkg

// File: core/edge_latch.sv
// Edge catcher and synchroniser for one detector line.
`timescale 1ns/100ps
module edge_latch
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic line_in,
    input wire logic clear,
    output logic rise_seen,
    output logic fall_seen
);
    logic rise_lat_r;
    logic fall_lat_r;
    logic rise_meta_r;
    logic rise_sync_r;
    logic fall_meta_r;
    logic fall_sync_r;
    logic rise_hold_r;
    logic fall_hold_r;
    logic rise_clr;
    logic fall_clr;
    // Short pulse capture
    // Asynchronous latches hold a pulse narrower than one clock period.
    // A latch is released once its edge reaches the second stage, so the next edge is caught.
    // An edge that arrives during that hand-over, while the second stage holds the latch clear, is lost.
    assign rise_clr = clear | rise_sync_r;
    assign fall_clr = clear | fall_sync_r;
    always_ff @(posedge line_in or posedge rise_clr)
    begin
        if (rise_clr)
            rise_lat_r <= 1'b0;
        else
            rise_lat_r <= 1'b1;
    end
    always_ff @(negedge line_in or posedge fall_clr)
    begin
        if (fall_clr)
            fall_lat_r <= 1'b0;
        else
            fall_lat_r <= 1'b1;
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rise_meta_r <= 1'b0;
            rise_sync_r <= 1'b0;
            fall_meta_r <= 1'b0;
            fall_sync_r <= 1'b0;
            rise_hold_r <= 1'b0;
            fall_hold_r <= 1'b0;
        end
        else
        begin
            rise_meta_r <= rise_lat_r;
            rise_sync_r <= rise_meta_r;
            fall_meta_r <= fall_lat_r;
            fall_sync_r <= fall_meta_r;
            rise_hold_r <= rise_sync_r;
            fall_hold_r <= fall_sync_r;
        end
    end
    assign rise_seen = rise_sync_r & ~rise_hold_r;
    assign fall_seen = fall_sync_r & ~fall_hold_r;
endmodule : edge_latch

// File: core/gpio_port.sv
// Port pin control with lock and the edge line controller.
`timescale 1ns/100ps
`include "gpio_port_cfg.svh"
module gpio_port
#(
    parameter int NPINS = `NUM_PINS,
    parameter int NSRC = `NUM_SRC_PINS
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_we,
    input wire logic [3:0] cfg_pin,
    input wire gpio_port_pkg::pin_mode_e cfg_mode,
    input wire logic cfg_open_drain,
    input wire gpio_port_pkg::pull_e cfg_pull,
    input wire gpio_port_pkg::speed_e cfg_speed,
    input wire logic [`AF_W-1:0] cfg_af,
    input wire logic odr_we,
    input wire logic [NPINS-1:0] odr_data,
    input wire logic key_we,
    input wire logic key_bit,
    input wire logic key_rd,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic [NPINS-1:0] alt_out,
    input wire logic [NSRC-1:0] src_pins,
    input wire logic [`NUM_INT_LINES-1:0] internal_events,
    input wire logic boot_source_select_option,
    input wire logic boot_select_pin,
    input wire logic line_we,
    input wire logic [4:0] line_idx,
    input wire gpio_port_pkg::trig_e line_trig,
    input wire logic line_mask,
    input wire logic [`SEL_W-1:0] line_sel,
    input wire logic [`NUM_LINES-1:0] pend_clr,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pull_up_en,
    output logic [NPINS-1:0] pull_dn_en,
    output logic [2*NPINS-1:0] speed_sel,
    output logic [`AF_W*NPINS-1:0] af_sel,
    output logic [NPINS-1:0] pin_data,
    output logic lock_active,
    output logic boot_state,
    output logic [`NUM_LINES-1:0] pending,
    output logic [`NUM_LINES-1:0] irq_req,
    output logic [`NUM_LINES-1:0] event_req
);
    import gpio_port_pkg::*;
    typedef enum {KEY_IDLE, KEY_ONE, KEY_ZERO, KEY_TWO} key_state_e;
    pin_mode_e mode_r [NPINS];
    pin_mode_e mode_nxt [NPINS];
    logic [NPINS-1:0] od_r, od_nxt;
    pull_e pull_r [NPINS];
    pull_e pull_nxt [NPINS];
    speed_e speed_r [NPINS];
    speed_e speed_nxt [NPINS];
    logic [`AF_W-1:0] af_r [NPINS];
    logic [`AF_W-1:0] af_nxt [NPINS];
    logic [NPINS-1:0] odr_r, odr_nxt;
    key_state_e key_r, key_nxt;
    logic lock_r, lock_nxt;
    logic boot_r, boot_nxt;
    logic boot_seen_r, boot_seen_nxt;
    trig_e trig_r [`NUM_LINES];
    trig_e trig_nxt [`NUM_LINES];
    logic [`NUM_LINES-1:0] mask_r, mask_nxt;
    logic [`SEL_W-1:0] sel_r [`NUM_CFG_LINES];
    logic [`SEL_W-1:0] sel_nxt [`NUM_CFG_LINES];
    logic [`NUM_LINES-1:0] pend_r, pend_nxt;
    logic [`NUM_LINES-1:0] line_src, rise_seen, fall_seen, hit;
    logic [`NUM_LINES-1:0] evt_r, evt_nxt;
    logic [NPINS-1:0] out_nxt, oe_nxt, pu_nxt, pd_nxt, din_nxt;
    logic [2*NPINS-1:0] spd_nxt;
    logic [`AF_W*NPINS-1:0] afo_nxt;

    genvar g;
    generate
        for (g = 0; g < `NUM_LINES; g++)
        begin : g_line
            if (g < `NUM_CFG_LINES)
            begin : g_cfg
                assign line_src[g] = (sel_r[g] < NSRC) ? src_pins[sel_r[g]] : 1'b0;
            end
            else
            begin : g_int
                assign line_src[g] = internal_events[g-`NUM_CFG_LINES];
            end
            edge_latch u_edge
            (
                .clock(clock),
                .rst_n(rst_n),
                .line_in(line_src[g]),
                .clear(~rst_n),
                .rise_seen(rise_seen[g]),
                .fall_seen(fall_seen[g])
            );
            assign hit[g] = (rise_seen[g] && trig_r[g][0]) || (fall_seen[g] && trig_r[g][1]);
        end
    endgenerate

    always_comb
    begin
        od_nxt = od_r;
        odr_nxt = odr_r;
        lock_nxt = lock_r;
        key_nxt = key_r;
        boot_nxt = boot_r;
        boot_seen_nxt = 1'b1;
        mask_nxt = mask_r;
        for (int i = 0; i < NPINS; i++)
        begin
            mode_nxt[i] = mode_r[i];
            pull_nxt[i] = pull_r[i];
            speed_nxt[i] = speed_r[i];
            af_nxt[i] = af_r[i];
        end
        for (int i = 0; i < `NUM_LINES; i++)
            trig_nxt[i] = trig_r[i];
        for (int i = 0; i < `NUM_CFG_LINES; i++)
            sel_nxt[i] = sel_r[i];
        if (!boot_seen_r && !boot_source_select_option)
            boot_nxt = boot_select_pin;
        if (odr_we)
            odr_nxt = odr_data;
        if (cfg_we)
        begin
            mode_nxt[cfg_pin] = cfg_mode;
            od_nxt[cfg_pin] = cfg_open_drain;
            pull_nxt[cfg_pin] = cfg_pull;
            speed_nxt[cfg_pin] = cfg_speed;
            if (!lock_r)
                af_nxt[cfg_pin] = cfg_af;
        end
        unique case (key_r)
            KEY_IDLE: if (key_we) key_nxt = key_bit ? KEY_ONE : KEY_IDLE;
            KEY_ONE: if (key_we) key_nxt = key_bit ? KEY_IDLE : KEY_ZERO;
                     else if (key_rd) key_nxt = KEY_IDLE;
            KEY_ZERO: if (key_we) key_nxt = key_bit ? KEY_TWO : KEY_IDLE;
                      else if (key_rd) key_nxt = KEY_IDLE;
            KEY_TWO:
            begin
                if (key_rd)
                    lock_nxt = 1'b1;
                if (key_rd || key_we)
                    key_nxt = KEY_IDLE;
            end
        endcase
        if (line_we && line_idx < `NUM_LINES)
        begin
            trig_nxt[line_idx] = line_trig;
            mask_nxt[line_idx] = line_mask;
            if (line_idx < `NUM_CFG_LINES)
                sel_nxt[line_idx[3:0]] = line_sel;
        end
        pend_nxt = (pend_r & ~pend_clr) | (hit & ~mask_r);
        evt_nxt = hit & ~mask_r;
    end

    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            out_nxt[i] = (mode_r[i] == MODE_ALT) ? alt_out[i] : odr_r[i];
            oe_nxt[i] = (mode_r[i] == MODE_OUTPUT) || (mode_r[i] == MODE_ALT);
            if (od_r[i] && out_nxt[i])
                oe_nxt[i] = 1'b0;
            if (od_r[i])
                out_nxt[i] = 1'b0;
            if (i == `SHARED_PIN)
            begin
                oe_nxt[i] = 1'b0;
                out_nxt[i] = 1'b0;
            end
            pu_nxt[i] = (mode_r[i] != MODE_ANALOG) && (pull_r[i] == PULL_UP);
            pd_nxt[i] = (mode_r[i] != MODE_ANALOG) && (pull_r[i] == PULL_DOWN);
            spd_nxt[2*i +: 2] = speed_r[i];
            afo_nxt[`AF_W*i +: `AF_W] = af_r[i];
            din_nxt[i] = (mode_r[i] == MODE_ANALOG) ? 1'b0 : pin_in[i];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NPINS; i++)
            begin
                mode_r[i] <= MODE_INPUT;
                pull_r[i] <= PULL_NONE;
                speed_r[i] <= SPD_400K;
                af_r[i] <= '0;
            end
            for (int i = 0; i < `NUM_LINES; i++)
                trig_r[i] <= TRIG_NONE;
            for (int i = 0; i < `NUM_CFG_LINES; i++)
                sel_r[i] <= '0;
            od_r <= '0;
            odr_r <= '0;
            key_r <= KEY_IDLE;
            lock_r <= 1'b0;
            boot_r <= 1'b0;
            boot_seen_r <= 1'b0;
            mask_r <= '1;
            pend_r <= '0;
            evt_r <= '0;
            pin_out <= '0;
            pin_oe <= '0;
            pull_up_en <= '0;
            pull_dn_en <= '0;
            speed_sel <= '0;
            af_sel <= '0;
            pin_data <= '0;
        end
        else
        begin
            for (int i = 0; i < NPINS; i++)
            begin
                mode_r[i] <= mode_nxt[i];
                pull_r[i] <= pull_nxt[i];
                speed_r[i] <= speed_nxt[i];
                af_r[i] <= af_nxt[i];
            end
            for (int i = 0; i < `NUM_LINES; i++)
                trig_r[i] <= trig_nxt[i];
            for (int i = 0; i < `NUM_CFG_LINES; i++)
                sel_r[i] <= sel_nxt[i];
            od_r <= od_nxt;
            odr_r <= odr_nxt;
            key_r <= key_nxt;
            lock_r <= lock_nxt;
            boot_r <= boot_nxt;
            boot_seen_r <= boot_seen_nxt;
            mask_r <= mask_nxt;
            pend_r <= pend_nxt;
            evt_r <= evt_nxt;
            pin_out <= out_nxt;
            pin_oe <= oe_nxt;
            pull_up_en <= pu_nxt;
            pull_dn_en <= pd_nxt;
            speed_sel <= spd_nxt;
            af_sel <= afo_nxt;
            pin_data <= din_nxt;
        end
    end

    assign lock_active = lock_r;
    assign boot_state = boot_r;
    assign pending = pend_r;
    // Interrupt request follows the sticky pending bit.
    assign irq_req = pend_r;
    assign event_req = evt_r;

    // Assertions.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence lock_seq;
        key_we && key_bit ##1 key_we && !key_bit ##1 key_we && key_bit ##1 key_rd;
    endsequence
    AST_LOCK_SET: assert property (lock_seq |=> lock_active)
        else $error("Lock not set after key sequence.");
    AST_LOCK_HOLD: assert property (lock_active |=> lock_active)
        else $error("Lock dropped before reset.");
    AST_AF_FROZEN: assert property (lock_r |=> $stable(af_r[cfg_pin]))
        else $error("Alternate function changed while locked.");
    AST_BOOT_NODRIVE: assert property (!pin_oe[`SHARED_PIN])
        else $error("Shared boot pin driven.");
    AST_PEND_STICKY: assert property (pend_r[0] && !pend_clr[0] |=> pend_r[0])
        else $error("Pending bit lost without clear.");
    AST_PEND_CLR: assert property (pend_clr[0] && !(hit[0] && !mask_r[0]) |=> !pend_r[0])
        else $error("Pending bit not cleared.");
    AST_MASKED: assert property (mask_r[1] && !pend_r[1] && !pend_clr[1] |=> !pend_r[1])
        else $error("Masked line raised pending.");
    AST_HIT_PEND: assert property (hit[2] && !mask_r[2] |=> pend_r[2] && event_req[2])
        else $error("Edge not recorded.");
endmodule : gpio_port

// File: testbench/pin_model.sv
// Pin-side model that resolves each wire from drivers, pulls and a floating pattern.
`timescale 1ns/100ps
module pin_model
(
    input wire logic clock,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pull_up_en,
    input wire logic [15:0] pull_dn_en,
    output logic [15:0] pin_in
);
    logic [15:0] float_r = 16'h5555;
    // A floating pin keeps changing, so a stale level can never pass for data.
    always_ff @(posedge clock)
        float_r <= ~float_r;
    always_comb
        for (int i = 0; i < 16; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : pull_up_en[i] ? 1'b1 :
                pull_dn_en[i] ? 1'b0 : float_r[i];
endmodule : pin_model

// File: testbench/testbench.sv
// Self-checking bench for the port and edge line controller.
`timescale 1ns/100ps
module testbench;
    import gpio_port_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_we = 1'b0, cfg_open_drain = 1'b0, odr_we = 1'b0;
    logic [3:0] cfg_pin = 4'h0, cfg_af = 4'h0;
    pin_mode_e cfg_mode = MODE_INPUT;
    pull_e cfg_pull = PULL_NONE;
    speed_e cfg_speed = SPD_400K;
    trig_e line_trig = TRIG_NONE;
    logic [15:0] odr_data = 16'h0000, alt_out = 16'h0000, pin_in;
    logic key_we = 1'b0, key_bit = 1'b0, key_rd = 1'b0, line_we = 1'b0, line_mask = 1'b1;
    logic [37:0] src_pins = 38'h0;
    logic [9:0] internal_events = 10'h0;
    logic boot_source_select_option = 1'b0, boot_select_pin = 1'b1;
    logic [4:0] line_idx = 5'h0;
    logic [5:0] line_sel = 6'h0, sel = 6'h0;
    logic [25:0] pend_clr = 26'h0, pending, irq_req, event_req;
    logic [15:0] pin_out, pin_oe, pull_up_en, pull_dn_en, pin_data;
    logic [31:0] speed_sel;
    logic [63:0] af_sel;
    logic lock_active, boot_state;
    logic [31:0] seed = 32'h734c3434;
    int failures = 0, compares = 0;
    gpio_port gpio_port_i (.clock(clock), .rst_n(rst_n), .cfg_we(cfg_we), .cfg_pin(cfg_pin),
        .cfg_mode(cfg_mode), .cfg_open_drain(cfg_open_drain), .cfg_pull(cfg_pull),
        .cfg_speed(cfg_speed), .cfg_af(cfg_af), .odr_we(odr_we), .odr_data(odr_data),
        .key_we(key_we), .key_bit(key_bit), .key_rd(key_rd), .pin_in(pin_in),
        .alt_out(alt_out), .src_pins(src_pins), .internal_events(internal_events),
        .boot_source_select_option(boot_source_select_option),
        .boot_select_pin(boot_select_pin), .line_we(line_we), .line_idx(line_idx),
        .line_trig(line_trig), .line_mask(line_mask), .line_sel(line_sel),
        .pend_clr(pend_clr), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_dn_en(pull_dn_en), .speed_sel(speed_sel), .af_sel(af_sel),
        .pin_data(pin_data), .lock_active(lock_active), .boot_state(boot_state),
        .pending(pending), .irq_req(irq_req), .event_req(event_req));
    pin_model pin_model_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .pin_in(pin_in));
    always #10 clock = ~clock;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic hit(input trig_e t, input logic up);
        return t == TRIG_BOTH || t == (up ? TRIG_RISE : TRIG_FALL);
    endfunction : hit
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step
    task automatic cfg(input int p, input pin_mode_e m, input logic od, input pull_e pu,
        input speed_e s, input logic [3:0] a);
        {cfg_pin, cfg_mode, cfg_open_drain, cfg_pull, cfg_speed, cfg_af} = {4'(p), m, od, pu, s, a};
        cfg_we = 1'b1;
        step(1);
        cfg_we = 1'b0;
        step(2);
    endtask : cfg
    task automatic key(input logic we, input logic b);
        {key_we, key_bit, key_rd} = {we, b, ~we};
        step(1);
    endtask : key
    task automatic line(input int l, input trig_e t, input logic m, input logic [5:0] s);
        {line_idx, line_trig, line_mask, line_sel, sel} = {5'(l), t, m, s, s};
        line_we = 1'b1;
        step(1);
        line_we = 1'b0;
        step(2);
    endtask : line
    task automatic edge_run(input int l, input trig_e t, input logic m, input logic up,
        input logic pw);
        logic ev;
        logic exp;
        ev = 1'b0;
        exp = !m && hit(t, up);
        if (l < 16) src_pins[sel] = up; else internal_events[l-16] = up;
        if (pw)
        begin
            #5;
            if (l < 16) src_pins[sel] = ~up; else internal_events[l-16] = ~up;
        end
        repeat (8)
        begin
            @(negedge clock);
            ev = ev | event_req[l];
        end
        check(irq_req[l], exp);
        check(ev, exp);
        pend_clr[l] = 1'b1;
        step(1);
        pend_clr[l] = 1'b0;
        step(2);
        check(pending[l], 1'b0);
    endtask : edge_run
    initial
    begin
        int p;
        int l;
        logic od;
        logic [15:0] w;
        speed_e s;
        logic [3:0] a;
        pull_e pu;
        alt_out = 16'(rnd());
        step(10);
        rst_n = 1'b1;
        step(2);
        check(boot_state, 1'b1);
        check({lock_active, pin_oe}, 17'h0);
        check(pending, 26'h0);
        boot_select_pin = 1'b0;
        step(2);
        check(boot_state, 1'b1);
        for (int k = 0; k < 6; k++)
        begin
            p = (k == 0) ? 9 : rnd() % 16;
            {w, od, s, a} = {16'(rnd()), 1'(rnd()), speed_e'(rnd() % 4), 4'(rnd())};
            {odr_data, odr_we} = {w, 1'b1};
            step(1);
            odr_we = 1'b0;
            cfg(p, MODE_OUTPUT, od, PULL_NONE, s, a);
            check(pin_oe[p], p != 9 && !(od && w[p]));
            check(speed_sel[2*p +: 2], s);
            check(af_sel[4*p +: 4], a);
            if (p != 9 && !od) check(pin_out[p], w[p]);
        end
        for (int k = 0; k < 3; k++)
        begin
            p = (k == 0) ? 9 : rnd() % 16;
            pu = pull_e'(k);
            cfg(p, MODE_INPUT, 1'b0, pu, SPD_400K, 4'h0);
            step(2);
            check({pull_up_en[p], pull_dn_en[p]}, {pu == PULL_UP, pu == PULL_DOWN});
            if (pu != PULL_NONE) check(pin_data[p], pu == PULL_UP);
        end
        cfg(p, MODE_ANALOG, 1'b0, PULL_UP, SPD_400K, 4'h0);
        check({pull_up_en[p], pull_dn_en[p], pin_oe[p], pin_data[p]}, 4'h0);
        for (int k = 0; k < 4; k++)
        begin
            l = rnd() % 16;
            line(l, trig_e'(k), 1'b0, 6'(rnd() % 38));
            edge_run(l, trig_e'(k), 1'b0, 1'b1, 1'b0);
            edge_run(l, trig_e'(k), 1'b0, 1'b0, 1'b0);
        end
        l = 16 + rnd() % 10;
        line(l, TRIG_BOTH, 1'b0, 6'h0);
        edge_run(l, TRIG_BOTH, 1'b0, 1'b1, 1'b0);
        edge_run(l, TRIG_BOTH, 1'b0, 1'b0, 1'b0);
        l = rnd() % 16;
        line(l, TRIG_BOTH, 1'b1, 6'(rnd() % 38));
        edge_run(l, TRIG_BOTH, 1'b1, 1'b1, 1'b0);
        edge_run(l, TRIG_BOTH, 1'b1, 1'b0, 1'b0);
        line(l, TRIG_RISE, 1'b0, 6'd37);
        edge_run(l, TRIG_RISE, 1'b0, 1'b1, 1'b1);
        p = rnd() % 16;
        cfg(p, MODE_ALT, 1'b0, PULL_NONE, SPD_2M, 4'h5);
        if (p != 9) check(pin_out[p], alt_out[p]);
        key(1'b1, 1'b1);
        key(1'b1, 1'b0);
        key(1'b1, 1'b0);
        key(1'b1, 1'b1);
        key(1'b0, 1'b0);
        {key_we, key_rd} = 2'b00;
        step(2);
        check(lock_active, 1'b0);
        key(1'b1, 1'b1);
        key(1'b1, 1'b0);
        key(1'b1, 1'b1);
        key(1'b0, 1'b0);
        {key_we, key_rd} = 2'b00;
        step(2);
        check(lock_active, 1'b1);
        cfg(p, MODE_ALT, 1'b0, PULL_NONE, SPD_40M, 4'ha);
        check({af_sel[4*p +: 4], speed_sel[2*p +: 2]}, {4'h5, SPD_40M});
        {boot_source_select_option, boot_select_pin, rst_n} = 3'b110;
        step(10);
        rst_n = 1'b1;
        step(2);
        check({boot_state, lock_active}, 2'b00);
        close_out();
    end
endmodule : testbench
